// *** sim/psu_dma_model.sv ***
// psu_dma_model.sv: peripheral dma stand-in feeding member duty values.
// assumes members ch0 and ch1 only, and a bench that leaves the port free.
`timescale 1ns/10ps
module psu_dma (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // bench control: run, idle cycles after each write less one, values
  input wire run,
  input wire [1:0] gap,
  input wire [31:0] duty0,
  input wire [31:0] duty1,
  // request in, duty write out
  input wire dma_req,
  output reg dma_wr = 1'b0,
  output reg [31:0] dma_data
);
  reg idx;
  reg [1:0] idle;
  // writes repeat after each idle gap while the request holds; data lines scramble once not writing
  always @(posedge ref_clk) begin
    dma_data <= ~dma_data;
    dma_wr <= 1'b0;
    if (reset || !run) begin
      idx <= 1'b0;
      idle <= 2'h0;
    end else if (dma_wr)
      idle <= gap;
    else if (idle != 2'h0)
      idle <= idle - 2'h1;
    else if (dma_req) begin
      dma_wr <= 1'b1;
      dma_data <= idx ? duty1 : duty0;
      idx <= ~idx;
    end
  end
endmodule

// *** sim/psu_sync_group_asserts.sv ***
// psu_sync_group_asserts.sv: port-level checker for the sync channel group.
// assumes a bind onto psu_sync_group; method and mask are shadowed from writes.
`timescale 1ns/10ps
`include "psu_map.vh"
module psu_chk (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  // dma, outputs and irq
  input wire dma_req,
  input wire compare_match,
  input wire [`PSU_NCHAN-1:0] pwm_out,
  input wire irq
);
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  reg [1:0] meth;
  reg [3:0] mask;
  // method code 3 is refused, so the shadow keeps the old code
  always @(posedge ref_clk) begin
    if (reset) begin
      meth <= 2'h0;
      mask <= 4'h0;
    end else if (reg_write) begin
      if (reg_addr == 8'h08 && reg_wdata[17:16] != 2'h3)
        meth <= reg_wdata[17:16];
      if (reg_addr == 8'h0c)
        mask <= mask | reg_wdata[3:0];
      if (reg_addr == 8'h0d)
        mask <= mask & ~reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  quiet_reset_a: assert property (
    $past(reset) |-> pwm_out == '0 && !dma_req && !irq)
    else $error("outputs active right after reset");
  stop_all_a: assert property (
    reg_write && reg_addr == 8'h02 && reg_wdata[3:0] == 4'hf |-> ##2 pwm_out == '0)
    else $error("outputs still running after full disable");
  dma_mode_a: assert property (
    dma_req |-> meth == 2'h2)
    else $error("dma request outside method 2");
  dma_fall_a: assert property (
    $fell(dma_req) |-> $past(reg_write) || $past(reg_read))
    else $error("dma request dropped without port traffic");
  irq_mask_a: assert property (
    irq |-> mask[0] || mask[3])
    else $error("irq raised with every flag masked");
  mask_read_a: assert property (
    reg_read && reg_addr == 8'h0e |=> reg_rdata[0] == mask[0] && reg_rdata[3] == mask[3])
    else $error("mask readback wrong");
  mode_read_a: assert property (
    reg_read && reg_addr == 8'h08 |=> reg_rdata[17:16] == meth)
    else $error("method readback wrong");
  unmapped_zero_a: assert property (
    reg_read && reg_addr == 8'h05 |=> reg_rdata == 32'h0)
    else $error("unmapped index read nonzero");
  rdata_hold_a: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule

// *** sim/tb_top.sv ***
// tb_top.sv: self-checking bench for the sync group and its update control.
// assumes the design, dma model and checker are compiled before this file.
`timescale 1ns/10ps
`include "psu_map.vh"
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam [31:0] FF = 32'hffffffff;
  reg ref_clk;
  reg reset;
  reg [7:0] cpu_addr;
  reg [31:0] cpu_wdata;
  reg cpu_wr;
  reg cpu_rd;
  reg run;
  reg [1:0] gap;
  reg [31:0] dv0, dv1, seed, last, e, m, d;
  reg rd_d = 1'b0;
  reg cmp;
  reg [31:0] exp_q[$];
  reg [31:0] msk_q[$];
  integer error_cnt = 0;
  integer n_tests = 0;
  integer i, mx, mn;
  wire dma_wr, dma_req, irq;
  wire [31:0] dma_data, reg_rdata;
  wire [`PSU_NCHAN-1:0] pwm_out;
  // dma writes borrow the port; the bench keeps off it while a dma pair may be in flight
  wire [7:0] reg_addr = dma_wr ? `PSU_DMA_DUTY_PORT : cpu_addr;
  wire [31:0] reg_wdata = dma_wr ? dma_data : cpu_wdata;
  wire reg_write = cpu_wr | dma_wr;
  psu_sync_group dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(cpu_rd),
    .reg_rdata(reg_rdata), .dma_req(dma_req), .compare_match(cmp),
    .pwm_out(pwm_out), .irq(irq));
  psu_dma dma (.ref_clk(ref_clk), .reset(reset), .run(run), .gap(gap), .duty0(dv0),
    .duty1(dv1), .dma_req(dma_req), .dma_wr(dma_wr), .dma_data(dma_data));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  task pause(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // a spare edge after each strobe keeps a strobe from being driven twice at once
  task wr(input [7:0] a, input [31:0] v);
    begin
      cpu_addr <= a;
      cpu_wdata <= v;
      cpu_wr <= 1'b1;
      @(posedge ref_clk);
      cpu_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // a zero mask only fetches the value into last
  task rd(input [7:0] a, input [31:0] x, input [31:0] k);
    begin
      exp_q.push_back(x);
      msk_q.push_back(k);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge ref_clk);
      cpu_rd <= 1'b0;
      @(posedge ref_clk);
      last = reg_rdata;
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // clock, watchdog, read monitor
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  // read data are checked in the cycle after the strobe; the design holds them until the next read
  always @(posedge ref_clk) begin
    rd_d <= cpu_rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0)
        chk(reg_rdata & m, e & m);
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    cpu_addr = 8'h0;
    cpu_wdata = 32'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    run = 1'b0;
    gap = 2'h0;
    cmp = 1'b0;
    dv0 = 32'h0;
    dv1 = 32'h0;
    seed = 32'hff4606cd;
    reset = 1'b1;
    pause(2);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(8'h03, 32'h0, FF);
    rd(8'h09, 32'h0, FF);
    rd(8'h0f, 32'h0, FF);
    rd(8'h05, 32'h0, FF);
    // every method code, code 3 refused
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h08, i << 16);
      rd(8'h08, (i == 3 ? 2 : i) << 16, 32'h30000);
    end
    // method 0: ch1 joins with ch0, its own counter fields differ from ch0
    wr(8'h08, 32'h2);
    wr(8'h20, 32'h3);
    wr(8'h24, 32'h7);
    wr(8'h2c, 32'h3);
    wr(8'h01, 32'h1);
    rd(8'h03, 32'h3, 32'hf);
    wr(8'h02, 32'h2);
    rd(8'h03, 32'h1, 32'hf);
    wr(8'h01, 32'h2);
    rd(8'h03, 32'h3, 32'hf);
    seed = xs(seed);
    d = {29'h0, seed[2:0]} | 32'h1;
    wr(8'h22, d);
    wr(8'h2a, d);
    pause(150);
    rd(8'h29, 32'h0, FF);
    // unlock while stopped so no boundary takes it before the read-back;
    // the re-enable also restarts both member counters together
    wr(8'h02, 32'h1);
    wr(8'h09, 32'h1);
    rd(8'h09, 32'h1, 32'h1);
    wr(8'h01, 32'h1);
    pause(150);
    rd(8'h09, 32'h0, 32'h1);
    rd(8'h21, d, FF);
    rd(8'h29, d, FF);
    for (i = 0; i < 130; i = i + 1) begin
      @(posedge ref_clk);
      chk({31'h0, pwm_out[1]}, {31'h0, pwm_out[0]});
    end
    // method 1, count 2: live counter spans 0..2
    wr(8'h02, 32'h1);
    wr(8'h08, 32'h10002);
    wr(8'h20, 32'h0);
    wr(8'h0a, 32'h2);
    wr(8'h01, 32'h1);
    mx = 0;
    mn = 15;
    for (i = 0; i < 60; i = i + 1) begin
      rd(8'h0a, 32'h0, 32'h0);
      if (last[11:8] > mx)
        mx = last[11:8];
      if (last[11:8] < mn)
        mn = last[11:8];
    end
    chk(mx, 2);
    chk(mn, 0);
    // write ready reaches irq only while unmasked
    wr(8'h0c, 32'h1);
    rd(8'h0e, 32'h1, 32'h9);
    rd(8'h0f, 32'h1, 32'h1);
    for (i = 0; i < 100 && irq !== 1'b1; i = i + 1)
      @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h0f, 32'h1, 32'h1);
    rd(8'h0f, 32'h0, 32'h1);
    wr(8'h0d, 32'h1);
    mx = 0;
    for (i = 0; i < 80; i = i + 1) begin
      @(posedge ref_clk);
      if (irq !== 1'b0)
        mx = 1;
    end
    chk(mx, 0);
    rd(8'h0f, 32'h1, 32'h1);
    // duty and count commit alone; period waits for the unlock
    seed = xs(seed);
    d = {29'h0, seed[2:0]};
    wr(8'h22, d);
    wr(8'h0b, 32'h1);
    wr(8'h24, 32'h9);
    pause(80);
    rd(8'h21, d, FF);
    rd(8'h0a, 32'h1, 32'hf);
    rd(8'h23, 32'h7, FF);
    wr(8'h09, 32'h1);
    pause(40);
    rd(8'h23, 32'h9, FF);
    // method 2: first pair lands while stopped, so later pairs follow ready points
    wr(8'h02, 32'h1);
    wr(8'h08, 32'h20002);
    seed = xs(seed);
    dv0 <= {29'h0, seed[2:0]};
    dv1 <= {29'h0, seed[5:3]};
    gap <= {1'b0, seed[6]};
    run <= 1'b1;
    pause(8);
    wr(8'h01, 32'h1);
    pause(150);
    run <= 1'b0;
    pause(4);
    wr(8'h22, ~dv0);
    rd(8'h22, dv0, FF);
    rd(8'h21, dv0, FF);
    rd(8'h29, dv1, FF);
    mx = 0;
    for (i = 0; i < 40 && mx == 0; i = i + 1) begin
      rd(8'h0f, 32'h0, 32'h0);
      if (last[3] === 1'b1)
        mx = 1;
    end
    chk(mx, 1);
    // on-match: write ready waits for a compare pulse, not the commit
    wr(8'h08, 32'h120002);
    rd(8'h0f, 32'h0, 32'h0);
    pause(60);
    rd(8'h0f, 32'h0, 32'h1);
    cmp <= 1'b1;
    @(posedge ref_clk);
    cmp <= 1'b0;
    rd(8'h0f, 32'h1, 32'h1);
    wr(8'h02, 32'hf);
    rd(8'h03, 32'h0, 32'hf);
    report_and_stop;
  end
endmodule
bind psu_sync_group psu_chk chk_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .dma_req(dma_req), .compare_match(compare_match), .pwm_out(pwm_out), .irq(irq));

// *** src/psu_map.vh ***
// psu_map.vh: register offsets, field positions, method codes and counts
// for the synchronous-channel group and its update control.
// assumes word-indexed register port with 8-bit address.
`ifndef PSU_MAP_VH
`define PSU_MAP_VH

// register indices (byte address = 4 * index)
`define PSU_CHAN_ENABLE_REG 8'h01
`define PSU_CHAN_DISABLE_REG 8'h02
`define PSU_CHAN_STATUS_REG 8'h03
`define PSU_SYNC_GROUP_MODE_REG 8'h08
`define PSU_SYNC_UPDATE_CTRL_REG 8'h09
`define PSU_SYNC_UPDATE_PERIOD_REG 8'h0a
`define PSU_UPDATE_PERIOD_STAGING_REG 8'h0b
`define PSU_IRQ_MASK_SET 8'h0c
`define PSU_IRQ_MASK_CLR 8'h0d
`define PSU_IRQ_MASK_TWO 8'h0e
`define PSU_IRQ_STATUS_TWO 8'h0f
`define PSU_DMA_DUTY_PORT 8'h10
`define PSU_CHAN_BASE 8'h20
`define PSU_CHAN_STRIDE 8'h08
// per-channel sub-offsets
`define PSU_SUB_MODE 3'h0
`define PSU_SUB_DUTY 3'h1
`define PSU_SUB_DUTY_STG 3'h2
`define PSU_SUB_PERIOD 3'h3
`define PSU_SUB_PERIOD_STG 3'h4
`define PSU_SUB_DEADTIME 3'h5
`define PSU_SUB_DEADTIME_STG 3'h6

// sync mode register fields
`define PSU_SYNC_LSB 0
`define PSU_UPDATE_METHOD_SEL_LSB 16
`define PSU_DMA_REQ_ON_MATCH_BIT 20
`define PSU_DMA_REQ_COMPARE_SEL_LSB 21
// chan mode register fields
`define PSU_PRE_LSB 0
`define PSU_ALIGN_BIT 8
// status two flags
`define PSU_WRITE_READY_FLAG_BIT 0
`define PSU_DMA_UNDERRUN_FLAG_BIT 3

// update methods
`define PSU_UPDATE_METHOD_SEL_MANUAL 2'h0
`define PSU_UPDATE_METHOD_SEL_AUTO 2'h1
`define PSU_UPDATE_METHOD_SEL_DMA 2'h2

`define PSU_NCHAN 4
`define PSU_CNT_W 16
`define PSU_UPR_W 4
`define PSU_DT_W 12

`endif

// *** src/psu_prescaler.v ***
// psu_prescaler.v: divides ref_clk into power-of-two enable pulses.
// assumes one clock; selected tap used by the group counter.
`timescale 1ns/10ps
module psu_prescaler (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // divider select and pulse
  input wire [3:0] sel,
  output reg tick
);

  reg [10:0] div;

  // free-running divider; tick is one cycle per selected ratio
  always @(posedge ref_clk) begin
    if (reset) begin
      div <= 11'h000;
      tick <= 1'b0;
    end else begin
      div <= div + 11'h001;
      if (sel == 4'h0)
        tick <= 1'b1;
      else if (sel <= 4'ha)
        tick <= (div[sel - 4'h1 +: 1] == 1'b1) &&
          ((div & ((11'h001 << sel) - 11'h001)) == ((11'h001 << sel) - 11'h001));
      else
        tick <= 1'b0; // reserved selections give no tick, so the channel counter stalls while div keeps counting
    end
  end

endmodule

// *** src/psu_sync_group.v ***
// psu_sync_group.v: synchronous PWM channel group with staged updates.
// assumes a register master on ref_clk and a DMA engine writing the duty
// port; read data appear one cycle after the read strobe.
`timescale 1ns/10ps
`include "psu_map.vh"
module psu_sync_group (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // peripheral dma request and duty compare match
  output wire dma_req,
  input wire compare_match,
  // pwm outputs and irq
  output reg [`PSU_NCHAN-1:0] pwm_out,
  output wire irq
);

  localparam N = `PSU_NCHAN;
  localparam W = `PSU_CNT_W;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0] chan_pre [0:N-1];
  reg chan_align [0:N-1];
  reg [W-1:0] duty [0:N-1];
  reg [W-1:0] duty_stg [0:N-1];
  reg [W-1:0] period [0:N-1];
  reg [W-1:0] period_stg [0:N-1];
  reg [`PSU_DT_W-1:0] deadtime [0:N-1];
  reg [`PSU_DT_W-1:0] deadtime_stg [0:N-1];
  reg [W-1:0] cnt [0:N-1];
  reg [N-1:0] cnt_dir_down;
  reg [N-1:0] enabled;
  reg [N-1:0] sync_member_bit;
  reg [1:0] update_method_sel;
  reg dma_req_on_match;
  reg [2:0] dma_req_compare_sel;
  reg update_unlock_bit;
  reg [`PSU_UPR_W-1:0] update_period_count;
  reg [`PSU_UPR_W-1:0] upr_stg;
  reg [`PSU_UPR_W-1:0] upr_cnt;
  reg write_ready_flag;
  reg dma_underrun_flag;
  reg [1:0] irq_mask_two;
  reg [1:0] dma_idx;
  reg dma_done;
  reg dma_armed;
  reg group_start;

  // channel register decode used by read and write
  function chan_hit;
    input [7:0] a;
    begin
      chan_hit = (a >= `PSU_CHAN_BASE) && (a < (`PSU_CHAN_BASE + N * `PSU_CHAN_STRIDE));
    end
  endfunction

  // next member index after idx, 4 when none remains
  function [2:0] next_member;
    input [N-1:0] m;
    input [1:0] idx;
    integer k;
    begin
      next_member = 3'h4;
      for (k = N - 1; k >= 0; k = k - 1)
        if (k > idx && m[k])
          next_member = k[2:0];
    end
  endfunction

  wire [7:0] chan_off = reg_addr - `PSU_CHAN_BASE;
  wire [1:0] acc_ch = chan_off[4:3];
  wire [2:0] acc_sub = chan_off[2:0];
  wire wr_ch = reg_write && chan_hit(reg_addr);

  // channel 0 joins whenever any other channel does
  wire [N-1:0] member = (|sync_member_bit) ? (sync_member_bit | 4'h1) : 4'h0;
  wire auto_mode = (update_method_sel == `PSU_UPDATE_METHOD_SEL_AUTO) ||
    (update_method_sel == `PSU_UPDATE_METHOD_SEL_DMA);
  // member after the one the next dma duty write fills, 4 when that write completes the set
  wire [2:0] nxt_mem = next_member(member, dma_idx);

  // ----------------------------------------------------------------
  // per-channel counters and outputs
  // ----------------------------------------------------------------
  wire [N-1:0] tick;
  wire [N-1:0] bound;
  wire grp_bound = bound[0] && enabled[0];
  // manual commit: only once unlocked, at group boundary
  wire unlock_commit = update_unlock_bit && grp_bound;
  // automatic commit after count+1 periods
  wire auto_commit = auto_mode && grp_bound &&
    (upr_cnt == update_period_count);

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : chan
      // members take channel 0 prescaler, period and alignment
      wire [3:0] pre = member[g] ? chan_pre[0] : chan_pre[g];
      wire algn = member[g] ? chan_align[0] : chan_align[g];
      wire [W-1:0] per = member[g] ? period[0] : period[g];
      // members count on channel 0 ticks so counters stay aligned
      wire tk;
      psu_prescaler u_pre (
        .ref_clk(ref_clk),
        .reset(reset),
        .sel(pre),
        .tick(tk)
      );
      assign tick[g] = tk;
      wire ctick = member[g] ? tick[0] : tick[g];
      assign bound[g] = ctick && (algn ? (cnt_dir_down[g] && cnt[g] == {W{1'b0}}) :
        (cnt[g] >= per));
      wire sync_commit = member[g] && (unlock_commit ||
        (auto_commit && update_method_sel != `PSU_UPDATE_METHOD_SEL_MANUAL));
      wire own_commit = !member[g] && bound[g];
      // counter, double-buffer commit and output
      always @(posedge ref_clk) begin
        if (reset) begin
          cnt[g] <= {W{1'b0}};
          cnt_dir_down[g] <= 1'b0;
          duty[g] <= {W{1'b0}};
          period[g] <= {W{1'b0}};
          deadtime[g] <= {`PSU_DT_W{1'b0}};
          pwm_out[g] <= 1'b0;
        end else begin
          if (!enabled[g] || (member[g] && group_start)) begin
            cnt[g] <= {W{1'b0}}; // group restarts together
            cnt_dir_down[g] <= 1'b0;
          end else if (ctick) begin
            if (!algn)
              cnt[g] <= (cnt[g] >= per) ? {W{1'b0}} : cnt[g] + {{(W-1){1'b0}}, 1'b1};
            else if (!cnt_dir_down[g]) begin
              if (cnt[g] >= per) begin
                cnt_dir_down[g] <= 1'b1;
                cnt[g] <= cnt[g] - {{(W-1){1'b0}}, 1'b1};
              end else
                cnt[g] <= cnt[g] + {{(W-1){1'b0}}, 1'b1};
            end else if (cnt[g] == {W{1'b0}})
              cnt_dir_down[g] <= 1'b0;
            else
              cnt[g] <= cnt[g] - {{(W-1){1'b0}}, 1'b1};
          end
          // period and deadtime commit only through unlock for members
          if (own_commit || (member[g] && unlock_commit)) begin
            period[g] <= period_stg[g];
            deadtime[g] <= deadtime_stg[g];
          end
          // duty follows unlock in method 0, auto commit otherwise
          if (own_commit || (sync_commit && (auto_mode ? auto_commit : 1'b1)))
            duty[g] <= duty_stg[g];
          pwm_out[g] <= enabled[g] && (cnt[g] < duty[g]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes, enables, update control
  // ----------------------------------------------------------------
  wire wr_ena = reg_write && reg_addr == `PSU_CHAN_ENABLE_REG;
  wire wr_dis = reg_write && reg_addr == `PSU_CHAN_DISABLE_REG;
  wire rd_status_two = reg_read && reg_addr == `PSU_IRQ_STATUS_TWO;
  wire dma_wr = reg_write && reg_addr == `PSU_DMA_DUTY_PORT;
  // ready point: end of update period, or a compare_match pulse in method 1 or 2 when dma_req_on_match is set
  wire ready_evt = dma_req_on_match ? (compare_match && auto_mode) :
    auto_commit;
  integer i;

  always @(posedge ref_clk) begin
    if (reset) begin
      enabled <= 4'h0;
      sync_member_bit <= 4'h0;
      update_method_sel <= `PSU_UPDATE_METHOD_SEL_MANUAL;
      dma_req_on_match <= 1'b0;
      dma_req_compare_sel <= 3'h0;
      update_unlock_bit <= 1'b0;
      update_period_count <= 4'h0;
      upr_stg <= 4'h0;
      upr_cnt <= 4'h0;
      write_ready_flag <= 1'b0;
      dma_underrun_flag <= 1'b0;
      irq_mask_two <= 2'h0;
      dma_idx <= 2'h0;
      dma_done <= 1'b0;
      dma_armed <= 1'b0;
      group_start <= 1'b0;
      for (i = 0; i < N; i = i + 1) begin
        chan_pre[i] <= 4'h0;
        chan_align[i] <= 1'b0;
        duty_stg[i] <= {W{1'b0}};
        period_stg[i] <= {W{1'b0}};
        deadtime_stg[i] <= {`PSU_DT_W{1'b0}};
      end
    end else begin
      group_start <= wr_ena && reg_wdata[0] && !enabled[0];
      // enable and disable; channel 0 bit covers all members
      if (wr_ena)
        enabled <= enabled | reg_wdata[N-1:0] | (reg_wdata[0] ? member : 4'h0);
      else if (wr_dis)
        enabled <= enabled & ~(reg_wdata[N-1:0] | (reg_wdata[0] ? member : 4'h0));
      if (reg_write && reg_addr == `PSU_SYNC_GROUP_MODE_REG) begin
        sync_member_bit <= reg_wdata[`PSU_SYNC_LSB +: N];
        update_method_sel <= (reg_wdata[`PSU_UPDATE_METHOD_SEL_LSB +: 2] == 2'h3) ?
          update_method_sel : reg_wdata[`PSU_UPDATE_METHOD_SEL_LSB +: 2];
        dma_req_on_match <= reg_wdata[`PSU_DMA_REQ_ON_MATCH_BIT];
        dma_req_compare_sel <= reg_wdata[`PSU_DMA_REQ_COMPARE_SEL_LSB +: 3];
      end
      // unlock holds until the commit edge, a write wins over a clear
      if (reg_write && reg_addr == `PSU_SYNC_UPDATE_CTRL_REG && reg_wdata[0])
        update_unlock_bit <= 1'b1;
      else if (unlock_commit)
        update_unlock_bit <= 1'b0;
      if (reg_write && reg_addr == `PSU_SYNC_UPDATE_PERIOD_REG)
        update_period_count <= reg_wdata[`PSU_UPR_W-1:0];
      else if (auto_commit)
        update_period_count <= upr_stg;
      if (reg_write && reg_addr == `PSU_UPDATE_PERIOD_STAGING_REG)
        upr_stg <= reg_wdata[`PSU_UPR_W-1:0];
      // update period counter
      if (group_start || auto_commit)
        upr_cnt <= 4'h0;
      else if (auto_mode && grp_bound)
        upr_cnt <= upr_cnt + 4'h1;
      // ready and underrun flags: set wins over read clear
      if (ready_evt)
        write_ready_flag <= 1'b1;
      else if (rd_status_two)
        write_ready_flag <= 1'b0;
      if (update_method_sel == `PSU_UPDATE_METHOD_SEL_DMA && auto_commit && dma_armed && !dma_done)
        dma_underrun_flag <= 1'b1;
      else if (rd_status_two)
        dma_underrun_flag <= 1'b0;
      if (reg_write && reg_addr == `PSU_IRQ_MASK_SET)
        irq_mask_two <= irq_mask_two | {reg_wdata[`PSU_DMA_UNDERRUN_FLAG_BIT], reg_wdata[`PSU_WRITE_READY_FLAG_BIT]};
      else if (reg_write && reg_addr == `PSU_IRQ_MASK_CLR)
        irq_mask_two <= irq_mask_two & ~{reg_wdata[`PSU_DMA_UNDERRUN_FLAG_BIT], reg_wdata[`PSU_WRITE_READY_FLAG_BIT]};
      // dma duty port walks members in ascending order from channel 0
      if (ready_evt) begin
        dma_idx <= 2'h0;
        dma_done <= 1'b0;
        dma_armed <= 1'b1;
      end else if (dma_wr && update_method_sel == `PSU_UPDATE_METHOD_SEL_DMA && !dma_done) begin
        duty_stg[dma_idx] <= reg_wdata[W-1:0];
        dma_done <= (nxt_mem == 3'h4);
        dma_idx <= (nxt_mem == 3'h4) ? dma_idx : nxt_mem[1:0];
      end
      // per-channel register writes
      if (wr_ch) begin
        case (acc_sub)
          `PSU_SUB_MODE: begin
            chan_pre[acc_ch] <= reg_wdata[`PSU_PRE_LSB +: 4];
            chan_align[acc_ch] <= reg_wdata[`PSU_ALIGN_BIT];
          end
          `PSU_SUB_DUTY_STG: begin
            if (!(member[acc_ch] && update_method_sel == `PSU_UPDATE_METHOD_SEL_DMA))
              duty_stg[acc_ch] <= reg_wdata[W-1:0];
          end
          `PSU_SUB_PERIOD_STG: period_stg[acc_ch] <= reg_wdata[W-1:0];
          `PSU_SUB_DEADTIME_STG: deadtime_stg[acc_ch] <= reg_wdata[`PSU_DT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // request is high in method 2 while write ready is set and the member set is not yet complete
  assign dma_req = (update_method_sel == `PSU_UPDATE_METHOD_SEL_DMA) && write_ready_flag && !dma_done;
  assign irq = |({dma_underrun_flag, write_ready_flag} & irq_mask_two);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_read) begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        `PSU_CHAN_STATUS_REG: reg_rdata[N-1:0] <= enabled;
        `PSU_SYNC_GROUP_MODE_REG: begin
          reg_rdata[`PSU_SYNC_LSB +: N] <= sync_member_bit;
          reg_rdata[`PSU_UPDATE_METHOD_SEL_LSB +: 2] <= update_method_sel;
          reg_rdata[`PSU_DMA_REQ_ON_MATCH_BIT] <= dma_req_on_match;
          reg_rdata[`PSU_DMA_REQ_COMPARE_SEL_LSB +: 3] <= dma_req_compare_sel;
        end
        `PSU_SYNC_UPDATE_CTRL_REG: reg_rdata[0] <= update_unlock_bit;
        `PSU_SYNC_UPDATE_PERIOD_REG: begin
          reg_rdata[`PSU_UPR_W-1:0] <= update_period_count;
          reg_rdata[8 +: `PSU_UPR_W] <= upr_cnt;
        end
        `PSU_UPDATE_PERIOD_STAGING_REG: reg_rdata[`PSU_UPR_W-1:0] <= upr_stg;
        `PSU_IRQ_MASK_TWO: begin
          reg_rdata[`PSU_WRITE_READY_FLAG_BIT] <= irq_mask_two[0];
          reg_rdata[`PSU_DMA_UNDERRUN_FLAG_BIT] <= irq_mask_two[1];
        end
        `PSU_IRQ_STATUS_TWO: begin
          reg_rdata[`PSU_WRITE_READY_FLAG_BIT] <= write_ready_flag;
          reg_rdata[`PSU_DMA_UNDERRUN_FLAG_BIT] <= dma_underrun_flag;
        end
        default: begin
          if (chan_hit(reg_addr)) begin
            case (acc_sub)
              `PSU_SUB_MODE: begin
                reg_rdata[`PSU_PRE_LSB +: 4] <= chan_pre[acc_ch];
                reg_rdata[`PSU_ALIGN_BIT] <= chan_align[acc_ch];
              end
              `PSU_SUB_DUTY: reg_rdata[W-1:0] <= duty[acc_ch];
              `PSU_SUB_DUTY_STG: reg_rdata[W-1:0] <= duty_stg[acc_ch];
              `PSU_SUB_PERIOD: reg_rdata[W-1:0] <= period[acc_ch];
              `PSU_SUB_PERIOD_STG: reg_rdata[W-1:0] <= period_stg[acc_ch];
              `PSU_SUB_DEADTIME: reg_rdata[`PSU_DT_W-1:0] <= deadtime[acc_ch];
              `PSU_SUB_DEADTIME_STG: reg_rdata[`PSU_DT_W-1:0] <= deadtime_stg[acc_ch];
              default: reg_rdata <= 32'h0000_0000;
            endcase
          end
        end
      endcase
    end
  end

endmodule
